/* File: bench/asc_host_model.sv */
// Purpose: Host writing the registers and driving the pins
// Assumes: Requests change just after the falling edge
// Notes: Pins hold level between calls, as a driven line does
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  input wire logic i_clk,
  output logic o_sw_we,
  output logic [7:0] o_sw_d,
  output logic o_md_we,
  output logic [15:0] o_md_d,
  output logic [3:0] o_pins
);
  initial begin
    o_sw_we = 1'b0;
    o_sw_d = 8'h00;
    o_md_we = 1'b0;
    o_md_d = 16'h0000;
    o_pins = 4'h0;
  end
  task automatic wr_sw(input logic [7:0] d);
    @(negedge i_clk);
    o_sw_we = 1'b1;
    o_sw_d = d;
    @(negedge i_clk);
    o_sw_we = 1'b0;
  endtask
  task automatic wr_md(input logic [15:0] d);
    @(negedge i_clk);
    o_md_we = 1'b1;
    o_md_d = d;
    @(negedge i_clk);
    o_md_we = 1'b0;
  endtask
  // Waits out the synchroniser before returning
  task automatic pins(input logic [3:0] p);
    @(negedge i_clk);
    o_pins = p;
    repeat (4) @(negedge i_clk);
  endtask
endmodule
`default_nettype wire

/* File: bench/asc_switch_ctrl_checker.sv */
// Purpose: Port assertions for the switch control bank
// Assumes: Variant follows the bound instance's parameter
// Notes: Drives and readback leave the same flop edge
`timescale 1ns/1ps
`default_nettype none
module asc_switch_ctrl_checker #(
  parameter bit TWO_CONV = 1'b1
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic i_SW_CTRL_WE,
  input wire logic [7:0] i_SW_CTRL_WDATA,
  input wire logic [7:0] o_SW_CTRL_RDATA,
  input wire logic [15:0] o_PIN_MODE_RDATA,
  input wire logic o_CONV_A_SW,
  input wire logic o_CONV_B_SW,
  input wire logic o_AMP1_SW,
  input wire logic o_AMP2_SW,
  input wire logic o_CO1_NO_SW,
  input wire logic o_CO1_NC_SW,
  input wire logic o_CO2_NO_SW,
  input wire logic o_CO2_NC_SW,
  input wire logic [3:0] o_PIN_ASSIGNED
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  // Don't-care bit of the absent switch reads back as zero
  localparam logic [7:0] RD_MASK = TWO_CONV ? 8'hEF : 8'hBF;
  logic [7:0] r;
  logic free;
  assign r = o_SW_CTRL_RDATA;
  // No pin assigned, so drives must equal the register alone
  assign free = (o_PIN_ASSIGNED == 4'h0);
  sequence s_wr;
    i_SW_CTRL_WE;
  endsequence
  sequence s_wr_a;
    s_wr ##0 i_SW_CTRL_WDATA[7];
  endsequence
  AST_CONV_A_CLOSE: assert property (s_wr_a |=> o_CONV_A_SW)
    else $error("conv A open after write");
  AST_CONV_A_OPEN: assert property (free |-> o_CONV_A_SW == r[7])
    else $error("conv A drive wrong");
  AST_CONV_B: assert property (free |-> o_CONV_B_SW == r[6])
    else $error("conv B drive wrong");
  AST_AMP1: assert property (free |-> o_AMP1_SW == r[5])
    else $error("amp1 drive wrong");
  AST_AMP2: assert property (free |-> o_AMP2_SW == r[4])
    else $error("amp2 drive wrong");
  AST_ABSENT_SW: assert property (TWO_CONV ? (!o_AMP2_SW && !r[4]) : (!o_CONV_B_SW && !r[6]))
    else $error("absent switch active");
  AST_CO1: assert property (free |-> o_CO1_NO_SW == r[2] && o_CO1_NC_SW == (r[2] ^ r[3]))
    else $error("changeover 1 wrong");
  AST_CO2: assert property (free |-> o_CO2_NO_SW == r[0] && o_CO2_NC_SW == (r[0] ^ r[1]))
    else $error("changeover 2 wrong");
  AST_RESET_ZERO: assert property ($fell(I_RST) |-> r == 8'h00 && o_PIN_MODE_RDATA == 16'h0000)
    else $error("register not zero after reset");
  AST_WR_READBACK: assert property (s_wr |=> r == ($past(i_SW_CTRL_WDATA) & RD_MASK))
    else $error("readback lags or wrong");
endmodule
bind asc_switch_ctrl asc_switch_ctrl_checker #(.TWO_CONV(TWO_CONV)) i_chk (.I_CLOCK, .I_RST, .i_SW_CTRL_WE,
  .i_SW_CTRL_WDATA,
  .o_SW_CTRL_RDATA, .o_PIN_MODE_RDATA, .o_CONV_A_SW, .o_CONV_B_SW, .o_AMP1_SW, .o_AMP2_SW,
  .o_CO1_NO_SW, .o_CO1_NC_SW, .o_CO2_NO_SW, .o_CO2_NC_SW, .o_PIN_ASSIGNED);
`default_nettype wire

/* File: bench/test_analog_switch_control_logic.sv */
// Purpose: Directed bench for the switch control bank
// Assumes: i_dut is the two-converter variant, i_dut_amp the two-amplifier one
// Notes: Switch vector is conv A, conv B, amp1, amp2, co1 NO/NC, co2 NO/NC
`timescale 1ns/1ps
`default_nettype none
module test_analog_switch_control_logic;
  logic clk;
  logic rst;
  int mismatches;
  int total_checks;
  int cyc;
  wire logic sw_we;
  wire logic md_we;
  wire logic [7:0] sw_d;
  wire logic [15:0] md_d;
  wire logic [3:0] pin;
  wire logic [7:0] rd;
  wire logic [15:0] md;
  wire logic [7:0] sw;
  wire logic [3:0] asg;
  wire logic [3:0] lvl;
  wire logic [7:0] rd2;
  wire logic [7:0] sw2;
  asc_host_model i_host (.i_clk(clk), .o_sw_we(sw_we), .o_sw_d(sw_d), .o_md_we(md_we), .o_md_d(md_d),
    .o_pins(pin));
  asc_switch_ctrl i_dut (.I_CLOCK(clk), .I_RST(rst), .i_DIGITAL_PROG_PIN(pin), .i_SW_CTRL_WE(sw_we),
    .i_SW_CTRL_WDATA(sw_d), .i_PIN_MODE_WE(md_we), .i_PIN_MODE_WDATA(md_d), .o_SW_CTRL_RDATA(rd),
    .o_PIN_MODE_RDATA(md), .o_CONV_A_SW(sw[7]), .o_CONV_B_SW(sw[6]), .o_AMP1_SW(sw[5]), .o_AMP2_SW(sw[4]),
    .o_CO1_NO_SW(sw[3]), .o_CO1_NC_SW(sw[2]), .o_CO2_NO_SW(sw[1]), .o_CO2_NC_SW(sw[0]),
    .o_PIN_ASSIGNED(asg), .o_PIN_LEVEL(lvl));
  // Same stimulus into the two-amplifier variant
  asc_switch_ctrl #(.TWO_CONV(1'b0)) i_dut_amp (.I_CLOCK(clk), .I_RST(rst), .i_DIGITAL_PROG_PIN(pin),
    .i_SW_CTRL_WE(sw_we), .i_SW_CTRL_WDATA(sw_d), .i_PIN_MODE_WE(md_we), .i_PIN_MODE_WDATA(md_d),
    .o_SW_CTRL_RDATA(rd2), .o_PIN_MODE_RDATA(), .o_CONV_A_SW(sw2[7]), .o_CONV_B_SW(sw2[6]),
    .o_AMP1_SW(sw2[5]), .o_AMP2_SW(sw2[4]), .o_CO1_NO_SW(sw2[3]), .o_CO1_NC_SW(sw2[2]),
    .o_CO2_NO_SW(sw2[1]), .o_CO2_NC_SW(sw2[0]), .o_PIN_ASSIGNED(), .o_PIN_LEVEL());
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic t_reset();
    chk(rd, 8'h00);
    chk(md, 16'h0000);
    chk(sw, 8'h00);
    chk(sw2, 8'h00);
  endtask
  task automatic t_feedback();
    i_host.wr_sw(8'h80);
    chk(sw, 8'h80);
    i_host.wr_sw(8'hF0);
    chk(rd, 8'hE0);
    chk(sw, 8'hE0);
    i_host.wr_sw(8'h00);
    chk(sw, 8'h00);
  endtask
  task automatic t_changeover();
    logic [1:0] co;
    for (int m = 0; m < 4; m++) begin
      i_host.wr_sw({4'h0, m[1:0], m[1:0]});
      co = {m[0], m[0] ^ m[1]};
      chk(sw, {4'h0, co, co});
    end
  endtask
  // Pin 4 stays unassigned to show it counts as zero
  task automatic t_pins();
    i_host.wr_md({4'h0, asc_pkg::MODE_AMP1, asc_pkg::MODE_CO1, asc_pkg::MODE_CONV_A});
    chk(asg, 4'h7);
    i_host.wr_sw(8'h08);
    chk(sw, 8'h04);
    i_host.pins(4'h8);
    chk(sw, 8'h04);
    i_host.pins(4'h7);
    chk(lvl, 4'h7);
    chk(sw, 8'hA8);
    i_host.pins(4'h0);
    chk(sw, 8'h04);
  endtask
  // Pins steer conv B, amp2 and changeover 2; pin 1 unassigned
  task automatic t_two_amp();
    i_host.wr_sw(8'hF0);
    chk(rd2, 8'hB0);
    chk(sw2, 8'hB0);
    i_host.wr_md({asc_pkg::MODE_CO2, asc_pkg::MODE_AMP2, asc_pkg::MODE_CONV_B, 4'h0});
    chk(md, 16'h9750);
    chk(asg, 4'hE);
    i_host.wr_sw(8'h01);
    chk(sw, 8'h03);
    chk(sw2, 8'h03);
    i_host.pins(4'hE);
    chk(sw, 8'h43);
    chk(sw2, 8'h13);
    i_host.wr_sw(8'h02);
    chk(sw, 8'h42);
    chk(sw2, 8'h12);
    i_host.pins(4'h1);
    chk(sw, 8'h01);
    chk(sw2, 8'h01);
  endtask
  // Reset in mid-run must clear register, modes and drives
  task automatic t_mid_reset();
    @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    chk(rd, 8'h00);
    chk(rd2, 8'h00);
    chk(md, 16'h0000);
    chk(sw, 8'h00);
    chk(sw2, 8'h00);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      mismatches++;
      conclude();
    end
  end
  initial begin
    rst = 1'b1;
    mismatches = 0;
    total_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_feedback();
    t_changeover();
    t_pins();
    t_two_amp();
    t_mid_reset();
    conclude();
  end
endmodule
`default_nettype wire

/* File: hdl/asc_pin_sync.sv */
// Purpose: Two-stage synchroniser for the digital programmable pins
// Assumes: Pins are asynchronous to the clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module asc_pin_sync (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_pin,
  output logic [3:0] o_pin
);

  logic [3:0] meta_r;
  logic [3:0] sync_r;

  genvar g;
  generate
    for (g = 0; g < asc_pkg::PIN_COUNT; g++) begin : g_bit
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          meta_r[g] <= 1'b0;
          sync_r[g] <= 1'b0;
        end else begin
          meta_r[g] <= i_pin[g];
          sync_r[g] <= meta_r[g];
        end
      end
    end
  endgenerate

  assign o_pin = sync_r;

endmodule

`default_nettype wire

/* File: hdl/asc_pkg.sv */
// Purpose: Shared constants and carriers for the analog switch control logic
// Assumes: One 40 MHz clock; register writes arrive already decoded
// Notes: Pin mode codes for switch control are our own choice of encoding

package asc_pkg;

  // Clock figure, kept for reference by any timing derivation
  localparam int CLK_PERIOD_NS = 25;

  localparam int PIN_COUNT = 4;
  localparam int MODE_W = 4;
  localparam int SW_CTRL_W = 8;
  localparam int PIN_MODE_W = PIN_COUNT * MODE_W;

  // Reset values
  localparam logic [7:0] SW_CTRL_RESET = 8'h00;
  localparam logic [15:0] PIN_MODE_RESET = 16'h0000;
  localparam logic [7:0] DRIVE_RESET = 8'h00;

  // Switch control register bit positions, MSB first
  localparam int CONV_A_POS = 7;
  localparam int CONV_B_POS = 6;
  localparam int AMP1_POS = 5;
  localparam int AMP2_POS = 4;
  localparam int CO1_LSB = 2;
  localparam int CO2_LSB = 0;

  // Changeover field: bit 1 selects exclusive paths, bit 0 is the level
  localparam int CO_EXCL_BIT = 1;
  localparam int CO_LEVEL_BIT = 0;

  // Pin mode codes that assign a pin to a switch
  localparam logic [3:0] MODE_CONV_A = 4'h4;
  localparam logic [3:0] MODE_CONV_B = 4'h5;
  localparam logic [3:0] MODE_AMP1 = 4'h6;
  localparam logic [3:0] MODE_AMP2 = 4'h7;
  localparam logic [3:0] MODE_CO1 = 4'h8;
  localparam logic [3:0] MODE_CO2 = 4'h9;

  typedef struct packed {
    logic conv_a;
    logic conv_b;
    logic amp1;
    logic amp2;
    logic [1:0] co1;
    logic [1:0] co2;
  } asc_sw_ctrl_t;

  typedef struct packed {
    logic conv_a;
    logic conv_b;
    logic amp1;
    logic amp2;
    logic co1_no;
    logic co1_nc;
    logic co2_no;
    logic co2_nc;
  } asc_sw_drive_t;

endpackage

/* File: hdl/asc_switch_ctrl.sv */
// Purpose: Analog switch control register bank with pin override
// Assumes: Register writes come decoded from the serial interface on I_CLOCK
// Notes: Outputs are registered from next-state values, so no extra lag
//
// Overview of operation
// - Register bit or assigned pin closes converter A
// - Converter A opens only when all sources low
// - Pins not assigned count as zero
// - Two-converter variant: converter B bit-or-pins closes
// - Amplifier 1 switch closes on bit or pins
// - Two-amplifier variant: amplifier 2 bit-or-pins closes
// - Mode upper 0: both changeover paths follow level
// - Mode upper 1: normally-open follows, normally-closed inverts
// - Changeover 2 uses identical encoding
// - All control bits reset to zero
// - Register layout MSB: A, B, amp1, amp2, fields
// - Per-pin four-bit mode fields, reset zero
`timescale 1ns/1ps
`default_nettype none

module asc_switch_ctrl #(
  parameter bit TWO_CONV = 1'b1
) (
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic [3:0] i_DIGITAL_PROG_PIN,
  input wire logic i_SW_CTRL_WE,
  input wire logic [7:0] i_SW_CTRL_WDATA,
  input wire logic i_PIN_MODE_WE,
  input wire logic [15:0] i_PIN_MODE_WDATA,
  output logic [7:0] o_SW_CTRL_RDATA,
  output logic [15:0] o_PIN_MODE_RDATA,
  output logic o_CONV_A_SW,
  output logic o_CONV_B_SW,
  output logic o_AMP1_SW,
  output logic o_AMP2_SW,
  output logic o_CO1_NO_SW,
  output logic o_CO1_NC_SW,
  output logic o_CO2_NO_SW,
  output logic o_CO2_NC_SW,
  output logic [3:0] o_PIN_ASSIGNED,
  output logic [3:0] o_PIN_LEVEL
);

  asc_pkg::asc_sw_ctrl_t sw_ctrl_r;
  asc_pkg::asc_sw_ctrl_t sw_ctrl_nxt;
  logic [15:0] pin_mode_r;
  logic [15:0] pin_mode_nxt;
  logic [3:0] pin_sync;
  asc_pkg::asc_sw_drive_t drive_nxt;
  logic [3:0] assigned_nxt;
  logic [7:0] rdata_nxt;

  // Pins are asynchronous; their lag is the two synchroniser stages plus the output flop
  asc_pin_sync u_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_pin(i_DIGITAL_PROG_PIN),
    .o_pin(pin_sync)
  );

  // Next register values, shared by storage and drive decode
  always_comb begin
    sw_ctrl_nxt = sw_ctrl_r;
    if (i_SW_CTRL_WE) begin
      sw_ctrl_nxt = asc_pkg::asc_sw_ctrl_t'(i_SW_CTRL_WDATA);
    end
  end

  always_comb begin
    pin_mode_nxt = pin_mode_r;
    if (i_PIN_MODE_WE) begin
      pin_mode_nxt = i_PIN_MODE_WDATA;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      sw_ctrl_r <= asc_pkg::asc_sw_ctrl_t'(asc_pkg::SW_CTRL_RESET);
    end else begin
      sw_ctrl_r <= sw_ctrl_nxt;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      pin_mode_r <= asc_pkg::PIN_MODE_RESET;
    end else begin
      pin_mode_r <= pin_mode_nxt;
    end
  end

  // Decode from next values so a write shows on the same edge it lands
  asc_switch_decode #(
    .TWO_CONV(TWO_CONV)
  ) u_dec (
    .i_ctrl(sw_ctrl_nxt),
    .i_pin_mode(pin_mode_nxt),
    .i_pin(pin_sync),
    .o_drive(drive_nxt),
    .o_assigned(assigned_nxt)
  );

  // Don't-care bit of the absent switch reads as zero
  always_comb begin
    rdata_nxt = sw_ctrl_nxt;
    if (TWO_CONV) begin
      rdata_nxt[asc_pkg::AMP2_POS] = 1'b0;
    end else begin
      rdata_nxt[asc_pkg::CONV_B_POS] = 1'b0;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_SW_CTRL_RDATA <= asc_pkg::SW_CTRL_RESET;
    end else begin
      o_SW_CTRL_RDATA <= rdata_nxt;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_PIN_MODE_RDATA <= asc_pkg::PIN_MODE_RESET;
    end else begin
      o_PIN_MODE_RDATA <= pin_mode_nxt;
    end
  end

  // Feedback switches
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_CONV_A_SW <= 1'b0;
    end else begin
      o_CONV_A_SW <= drive_nxt.conv_a;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_CONV_B_SW <= 1'b0;
    end else begin
      o_CONV_B_SW <= drive_nxt.conv_b;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_AMP1_SW <= 1'b0;
    end else begin
      o_AMP1_SW <= drive_nxt.amp1;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_AMP2_SW <= 1'b0;
    end else begin
      o_AMP2_SW <= drive_nxt.amp2;
    end
  end

  // Changeover switches; reset leaves both paths open
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_CO1_NO_SW <= 1'b0;
      o_CO1_NC_SW <= 1'b0;
    end else begin
      o_CO1_NO_SW <= drive_nxt.co1_no;
      o_CO1_NC_SW <= drive_nxt.co1_nc;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_CO2_NO_SW <= 1'b0;
      o_CO2_NC_SW <= 1'b0;
    end else begin
      o_CO2_NO_SW <= drive_nxt.co2_no;
      o_CO2_NC_SW <= drive_nxt.co2_nc;
    end
  end

  // Status: which pins hold any switch mode code, absent switch included, and their sampled levels
  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      o_PIN_ASSIGNED <= 4'h0;
      o_PIN_LEVEL <= 4'h0;
    end else begin
      o_PIN_ASSIGNED <= assigned_nxt;
      o_PIN_LEVEL <= pin_sync;
    end
  end

endmodule

`default_nettype wire

/* File: hdl/asc_switch_decode.sv */
// Purpose: Combinational switch drive from register bits and assigned pins
// Assumes: Pins already synchronised
// Notes: Pins in any other mode count as zero
`timescale 1ns/1ps
`default_nettype none

module asc_switch_decode #(
  parameter bit TWO_CONV = 1'b1
) (
  input wire asc_pkg::asc_sw_ctrl_t i_ctrl,
  input wire logic [15:0] i_pin_mode,
  input wire logic [3:0] i_pin,
  output var asc_pkg::asc_sw_drive_t o_drive,
  output logic [3:0] o_assigned
);

  logic [3:0] on_conv_a;
  logic [3:0] on_conv_b;
  logic [3:0] on_amp1;
  logic [3:0] on_amp2;
  logic [3:0] on_co1;
  logic [3:0] on_co2;
  logic [3:0] used;

  genvar g;
  generate
    for (g = 0; g < asc_pkg::PIN_COUNT; g++) begin : g_pin
      logic [3:0] md;
      assign md = i_pin_mode[g*asc_pkg::MODE_W +: asc_pkg::MODE_W];
      // Unassigned pins masked to zero
      assign on_conv_a[g] = i_pin[g] & (md == asc_pkg::MODE_CONV_A);
      assign on_conv_b[g] = i_pin[g] & (md == asc_pkg::MODE_CONV_B);
      assign on_amp1[g] = i_pin[g] & (md == asc_pkg::MODE_AMP1);
      assign on_amp2[g] = i_pin[g] & (md == asc_pkg::MODE_AMP2);
      assign on_co1[g] = i_pin[g] & (md == asc_pkg::MODE_CO1);
      assign on_co2[g] = i_pin[g] & (md == asc_pkg::MODE_CO2);
      assign used[g] = (md == asc_pkg::MODE_CONV_A) | (md == asc_pkg::MODE_CONV_B) |
                       (md == asc_pkg::MODE_AMP1) | (md == asc_pkg::MODE_AMP2) |
                       (md == asc_pkg::MODE_CO1) | (md == asc_pkg::MODE_CO2);
    end
  endgenerate

  logic co1_act;
  logic co2_act;

  always_comb begin
    o_drive = '0;
    co1_act = i_ctrl.co1[asc_pkg::CO_LEVEL_BIT] | (|on_co1);
    co2_act = i_ctrl.co2[asc_pkg::CO_LEVEL_BIT] | (|on_co2);
    o_drive.conv_a = i_ctrl.conv_a | (|on_conv_a);
    o_drive.amp1 = i_ctrl.amp1 | (|on_amp1);
    if (TWO_CONV) begin
      o_drive.conv_b = i_ctrl.conv_b | (|on_conv_b);
    end else begin
      o_drive.amp2 = i_ctrl.amp2 | (|on_amp2);
    end
    o_drive.co1_no = co1_act;
    o_drive.co1_nc = i_ctrl.co1[asc_pkg::CO_EXCL_BIT] ? ~co1_act : co1_act;
    o_drive.co2_no = co2_act;
    o_drive.co2_nc = i_ctrl.co2[asc_pkg::CO_EXCL_BIT] ? ~co2_act : co2_act;
  end

  assign o_assigned = used;

endmodule

`default_nettype wire
